//--- inc/fcs_pkg.sv
// package of constants and types for the flash command sequencer
package fcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_PARAM0 = 8'h08; // address / command word
  localparam logic [7:0] OFS_PARAM1 = 8'h0C; // count / margin word
  localparam logic [7:0] OFS_PARAM2 = 8'h10; // data word
  localparam logic [7:0] OFS_PROT = 8'h14;
  localparam logic [7:0] OFS_SYSCTL = 8'h18;
  // status bit positions
  localparam int ST_CC = 7;
  localparam int ST_RDCOL = 6;
  localparam int ST_ACC = 5;
  localparam int ST_PV = 4;
  localparam int ST_MG = 0;
  // config bit positions
  localparam int CF_CMD_COMPLETE_IRQ_ENABLE = 7;
  localparam int CF_RCIE = 6;
  // sysctl bit positions
  localparam int SC_SPECIAL = 0;
  localparam int SC_SECURE = 1;
  localparam int SC_VLP = 2;
  localparam int SC_STOPREQ = 3;
  localparam int SC_MASS_ERASE_ENABLE_FIELD_LO = 4;
  // reset value and blocking mass-erase field code
  localparam logic [31:0] PROT_RST = 32'hFFFF_FFFF;
  localparam logic [1:0] MASS_ERASE_ENABLE_FIELD_BLOCK = 2'b10;
  // command codes
  localparam logic [7:0] CMD_RD1SEC = 8'h01;
  localparam logic [7:0] CMD_PGMCHK = 8'h02;
  localparam logic [7:0] CMD_RDRSRC = 8'h03;
  localparam logic [7:0] CMD_PGM4 = 8'h06;
  localparam logic [7:0] CMD_ERSSCR = 8'h09;
  localparam logic [7:0] CMD_RD1ALL = 8'h40;
  localparam logic [7:0] CMD_RDONCE = 8'h41;
  localparam logic [7:0] CMD_PGMONCE = 8'h43;
  localparam logic [7:0] CMD_ERSALL = 8'h44;
  localparam logic [7:0] CMD_VFYKEY = 8'h45;
  // geometry and timing
  localparam logic [23:0] FLASH_TOP = 24'h04_0000;
  localparam logic [5:0] ONCE_BYTES = 6'h3F; // last byte of 64-byte field
  localparam int EXEC_NS = 40;
  localparam int EXEC_CYC = (EXEC_NS + 3) / 4;
  typedef enum logic [3:0] {
    FCS_IDLE = 4'b0001,
    FCS_CHECK = 4'b0010,
    FCS_EXEC = 4'b0100,
    FCS_DONE = 4'b1000
  } fcs_state_t;
endpackage

//--- rtl/fcs_top.sv
// flash command sequencer with an AXI4-Lite register slave
// Overview of operation
// - normal and special modes gate commands
// - plain read; same-block read sets collision
// - param writes ignored while busy
// - launch ignored in very-low-power modes
// - write one clears complete flag, held low
// - errors block clearing the complete flag
// - bad code or address sets access error
// - protected program/erase sets protection violation
// - failed checks skip execution, complete set
// - run-time failures reported in margin flag
// - results stored, then complete flag set
// - decode 0x01, 0x02, 0x40 verify commands
// - decode 0x03 and 0x41 reads
// - decode 0x06 and 0x43 programs
// - decode 0x09, 0x44; full erase needs unprotected
// - decode 0x45 key compare, releases security
// - mode and security restrict command set
// - interrupts on completion and collision
// - stop mode waits for command end
//
// Our own choices: register access over AXI4-Lite and the address map.
module fcs_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi write address / data / response
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // array side
  input wire logic array_rd,
  input wire logic [23:0] array_rd_addr,
  input wire logic exec_fail,
  input wire logic [31:0] exec_result,
  input wire logic [31:0] backdoor_key,
  // events out
  output logic flash_irq,
  output logic stop_ack
);
  // register state
  logic cc_q, cc_d, rc_q, rc_d, acc_q, acc_d, pv_q, pv_d, mg_q, mg_d;
  logic cmd_complete_irq_enable_q, cmd_complete_irq_enable_d, rcie_q, rcie_d;
  logic [31:0] p0_q, p0_d, p1_q, p1_d, p2_q, p2_d, prot_q, prot_d, sc_q, sc_d;
  logic secure_q, secure_d;
  fcs_pkg::fcs_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  // bus state
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic irq_q, irq_d, sack_q, sack_d;
  // decode helpers
  logic wr_go, wr_hit, allowed, known, bad_par, prot_hit, launch;
  logic [7:0] code;
  logic [23:0] addr;
  logic [31:0] wmask;
  assign code = p0_q[31:24];
  assign addr = p0_q[23:0];
  assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign wr_go = aw_q && w_q && !bv_q;
  // command legality by code, mode and security
  always_comb begin
    known = 1'b1;
    case (code)
      fcs_pkg::CMD_RD1SEC, fcs_pkg::CMD_PGMCHK, fcs_pkg::CMD_RDRSRC,
      fcs_pkg::CMD_PGM4, fcs_pkg::CMD_ERSSCR, fcs_pkg::CMD_RD1ALL,
      fcs_pkg::CMD_RDONCE, fcs_pkg::CMD_PGMONCE, fcs_pkg::CMD_ERSALL,
      fcs_pkg::CMD_VFYKEY: known = 1'b1;
      default: known = 1'b0;
    endcase
    // special mode narrows the set when secured
    if (!sc_q[fcs_pkg::SC_SPECIAL] || !secure_q) begin
      allowed = known;
    end else if (sc_q[fcs_pkg::SC_MASS_ERASE_ENABLE_FIELD_LO +: 2] == fcs_pkg::MASS_ERASE_ENABLE_FIELD_BLOCK) begin
      allowed = 1'b0;
    end else begin
      allowed = (code == fcs_pkg::CMD_RD1ALL) || (code == fcs_pkg::CMD_ERSALL);
    end
    // per-command parameter checks
    bad_par = 1'b0;
    prot_hit = 1'b0;
    case (code)
      fcs_pkg::CMD_RD1SEC: bad_par = (addr >= fcs_pkg::FLASH_TOP) || (addr[1:0] != 2'b00) ||
        (p1_q[31:16] == 16'h0000) || (p1_q[7:0] > 8'h02);
      fcs_pkg::CMD_PGMCHK: bad_par = (addr >= fcs_pkg::FLASH_TOP) || (addr[1:0] != 2'b00) ||
        (p1_q[7:0] > 8'h02);
      fcs_pkg::CMD_PGM4, fcs_pkg::CMD_ERSSCR: begin
        bad_par = (addr >= fcs_pkg::FLASH_TOP) || (addr[1:0] != 2'b00);
        prot_hit = !prot_q[addr[17:13]];
      end
      fcs_pkg::CMD_RDONCE, fcs_pkg::CMD_PGMONCE: bad_par = (addr[23:6] != 18'h0_0000) ||
        (addr[1:0] != 2'b00);
      fcs_pkg::CMD_ERSALL: prot_hit = (prot_q != fcs_pkg::PROT_RST);
      default: bad_par = 1'b0;
    endcase
  end
  // launch: write one to complete flag, no errors, not low power
  assign wr_hit = wr_go && (awa_q == fcs_pkg::OFS_STATUS) && ws_q[0];
  assign launch = wr_hit && wd_q[fcs_pkg::ST_CC] && cc_q && !acc_q && !pv_q &&
    !wd_q[fcs_pkg::ST_ACC] && !wd_q[fcs_pkg::ST_PV] && !sc_q[fcs_pkg::SC_VLP];
  // sequencer and register file next state
  always_comb begin
    cc_d = cc_q;
    rc_d = rc_q;
    acc_d = acc_q;
    pv_d = pv_q;
    mg_d = mg_q;
    cmd_complete_irq_enable_d = cmd_complete_irq_enable_q;
    rcie_d = rcie_q;
    p0_d = p0_q;
    p1_d = p1_q;
    p2_d = p2_q;
    prot_d = prot_q;
    sc_d = sc_q;
    secure_d = secure_q;
    st_d = st_q;
    cnt_d = cnt_q;
    // register writes; error clear by write-one
    if (wr_go) begin
      case (awa_q)
        fcs_pkg::OFS_STATUS: if (ws_q[0]) begin
          if (wd_q[fcs_pkg::ST_ACC]) acc_d = 1'b0;
          if (wd_q[fcs_pkg::ST_PV]) pv_d = 1'b0;
          if (wd_q[fcs_pkg::ST_RDCOL]) rc_d = 1'b0;
        end
        fcs_pkg::OFS_CONFIG: if (ws_q[0]) begin
          cmd_complete_irq_enable_d = wd_q[fcs_pkg::CF_CMD_COMPLETE_IRQ_ENABLE];
          rcie_d = wd_q[fcs_pkg::CF_RCIE];
        end
        fcs_pkg::OFS_PARAM0: if (cc_q) p0_d = (p0_q & ~wmask) | (wd_q & wmask);
        fcs_pkg::OFS_PARAM1: if (cc_q) p1_d = (p1_q & ~wmask) | (wd_q & wmask);
        fcs_pkg::OFS_PARAM2: if (cc_q) p2_d = (p2_q & ~wmask) | (wd_q & wmask);
        fcs_pkg::OFS_PROT: if (cc_q) begin
          // normal mode may only add protection
          if (sc_q[fcs_pkg::SC_SPECIAL]) prot_d = (prot_q & ~wmask) | (wd_q & wmask);
          else prot_d = prot_q & (wd_q | ~wmask);
        end
        fcs_pkg::OFS_SYSCTL: sc_d = (sc_q & ~wmask) | (wd_q & wmask);
        default: sc_d = sc_q;
      endcase
    end
    // collision: set wins over clear
    if (array_rd && !cc_q && (array_rd_addr[23:17] == addr[23:17])) rc_d = 1'b1;
    case (st_q)
      fcs_pkg::FCS_IDLE: if (launch) begin
        cc_d = 1'b0;
        mg_d = 1'b0;
        st_d = fcs_pkg::FCS_CHECK;
      end
      fcs_pkg::FCS_CHECK: begin
        // a failed check ends the command here, nothing is executed
        cnt_d = 4'(fcs_pkg::EXEC_CYC);
        st_d = fcs_pkg::FCS_EXEC;
        if (!allowed || bad_par) acc_d = 1'b1;
        else if (prot_hit) pv_d = 1'b1;
        if (!allowed || bad_par || prot_hit) begin
          cc_d = 1'b1;
          st_d = fcs_pkg::FCS_IDLE;
        end
      end
      fcs_pkg::FCS_EXEC: if (cnt_q == 4'h0) st_d = fcs_pkg::FCS_DONE;
        else cnt_d = cnt_q - 4'h1;
      fcs_pkg::FCS_DONE: begin
        // results first, complete flag in the same update
        if (code == fcs_pkg::CMD_RDRSRC || code == fcs_pkg::CMD_RDONCE) p2_d = exec_result;
        if (code == fcs_pkg::CMD_VFYKEY && backdoor_key == p2_q) secure_d = 1'b0;
        else if (code == fcs_pkg::CMD_VFYKEY) acc_d = 1'b1;
        else if (exec_fail) mg_d = 1'b1;
        else if (code == fcs_pkg::CMD_RD1ALL || code == fcs_pkg::CMD_ERSALL)
          secure_d = 1'b0;
        cc_d = 1'b1;
        st_d = fcs_pkg::FCS_IDLE;
      end
      default: st_d = fcs_pkg::FCS_IDLE;
    endcase
  end
  // axi handshake next state
  always_comb begin
    // each slot loads while empty, so ready is just the empty flag
    aw_d = aw_q || s_axi_awvalid;
    w_d = w_q || s_axi_wvalid;
    awa_d = aw_q ? awa_q : s_axi_awaddr;
    wd_d = w_q ? wd_q : s_axi_wdata;
    ws_d = w_q ? ws_q : s_axi_wstrb;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = (awa_q[1:0] == 2'b00 && awa_q <= fcs_pkg::OFS_SYSCTL) ? 2'b00 : 2'b10;
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = 2'b00;
      rd_d = 32'h0000_0000;
      case (s_axi_araddr)
        fcs_pkg::OFS_STATUS: rd_d = 32'({cc_q, rc_q, acc_q, pv_q, 3'b000, mg_q});
        fcs_pkg::OFS_CONFIG: rd_d = 32'({cmd_complete_irq_enable_q, rcie_q, 6'b00_0000});
        fcs_pkg::OFS_PARAM0: rd_d = p0_q;
        fcs_pkg::OFS_PARAM1: rd_d = p1_q;
        fcs_pkg::OFS_PARAM2: rd_d = p2_q;
        fcs_pkg::OFS_PROT: rd_d = prot_q;
        fcs_pkg::OFS_SYSCTL: rd_d = {sc_q[31:2], secure_q, sc_q[0]};
        default: rr_d = 2'b10; // unmapped reads return zero
      endcase
    end
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    // interrupt level and stop handshake
    irq_d = (cmd_complete_irq_enable_q && cc_q) || (rcie_q && rc_q);
    sack_d = sc_q[fcs_pkg::SC_STOPREQ] && cc_q && st_q == fcs_pkg::FCS_IDLE;
  end
  // all state registers, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cc_q <= 1'b1;
      acc_q <= 1'b0;
      pv_q <= 1'b0;
      rc_q <= 1'b0;
      mg_q <= 1'b0;
      cmd_complete_irq_enable_q <= 1'b0;
      rcie_q <= 1'b0;
      p0_q <= 32'h0000_0000;
      p1_q <= 32'h0000_0000;
      p2_q <= 32'h0000_0000;
      prot_q <= fcs_pkg::PROT_RST;
      sc_q <= 32'h0000_0000;
      secure_q <= 1'b1;
      st_q <= fcs_pkg::FCS_IDLE;
      cnt_q <= 4'h0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= 2'b00;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
      irq_q <= 1'b0;
      sack_q <= 1'b0;
    end else begin
      cc_q <= cc_d;
      acc_q <= acc_d;
      pv_q <= pv_d;
      rc_q <= rc_d;
      mg_q <= mg_d;
      cmd_complete_irq_enable_q <= cmd_complete_irq_enable_d;
      rcie_q <= rcie_d;
      p0_q <= p0_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      prot_q <= prot_d;
      sc_q <= sc_d;
      secure_q <= secure_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      irq_q <= irq_d;
      sack_q <= sack_d;
    end
  end
  // outputs straight from flops
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  assign flash_irq = irq_q;
  assign stop_ack = sack_q;
  // checks on the sequencer
  a_launch_clears_cc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    launch && st_q == fcs_pkg::FCS_IDLE |=> !cc_q) else $error("launch left complete set");
  a_error_blocks_go: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (acc_q || pv_q) && cc_q |=> cc_q) else $error("launch despite error");
  a_vlp_blocks_go: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sc_q[fcs_pkg::SC_VLP] && cc_q |=> cc_q) else $error("launch in low power");
  a_param_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !cc_q |=> $stable(p0_q) && $stable(p1_q)) else $error("param changed busy");
  a_bad_cmd_acc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == fcs_pkg::FCS_CHECK && !known |=> acc_q && cc_q) else $error("bad code missed");
  a_prot_viol: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == fcs_pkg::FCS_CHECK && allowed && !bad_par && prot_hit |=> pv_q && cc_q)
    else $error("protection missed");
  a_check_skips_exec: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == fcs_pkg::FCS_CHECK && (!allowed || bad_par) |=> st_q == fcs_pkg::FCS_IDLE)
    else $error("executed bad command");
  a_busy_ends: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(cc_q) |-> ##[1:20] cc_q) else $error("command never ended");
  a_collision_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    array_rd && !cc_q && array_rd_addr[23:17] == addr[23:17] |=> rc_q)
    else $error("collision missed");
  a_secured_special: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == fcs_pkg::FCS_CHECK && sc_q[fcs_pkg::SC_SPECIAL] && secure_q &&
    code == fcs_pkg::CMD_PGM4 |=> acc_q) else $error("secure special accepted");
endmodule

//--- tb/fcs_flash_model.sv
// array-side model: uncommanded reads, run-time failure, read result and stored key
module fcs_flash_model #(
  parameter logic [31:0] KEY_WORD = 32'h5A5A_0F0F, // arbitrary stored key
  parameter logic [31:0] RESULT_WORD = 32'h1357_2468 // arbitrary read result
) (
  // clock
  input wire logic sys_clk,
  // bench controls
  input wire logic rd_req,
  input wire logic [23:0] rd_req_addr,
  input wire logic fail_req,
  // design side
  output logic array_rd,
  output logic [23:0] array_rd_addr,
  output logic exec_fail,
  output logic [31:0] exec_result,
  output logic [31:0] backdoor_key
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] last_q;
  // keep last read address so an idle bus never repeats it
  always_ff @(posedge sys_clk) if (rd_req) last_q <= rd_req_addr;
  // released address lines show the inverse of the last value
  assign array_rd = rd_req;
  assign array_rd_addr = rd_req ? rd_req_addr : ~last_q;
  assign exec_fail = fail_req;
  assign exec_result = RESULT_WORD;
  assign backdoor_key = KEY_WORD;
endmodule

//--- tb/fcs_top_tb.sv
// self-checking bench for the flash command sequencer
module fcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // constants and signals
  localparam logic [31:0] KEY = 32'h5A5A_0F0F; // arbitrary, same as model
  localparam logic [31:0] RES = 32'h1357_2468; // arbitrary, same as model
  localparam logic [31:0] CC = 32'(1) << fcs_pkg::ST_CC;
  localparam logic [31:0] RC = 32'(1) << fcs_pkg::ST_RDCOL;
  localparam logic [31:0] ACC = 32'(1) << fcs_pkg::ST_ACC;
  localparam logic [31:0] PV = 32'(1) << fcs_pkg::ST_PV;
  localparam logic [31:0] MG = 32'(1) << fcs_pkg::ST_MG;
  logic sys_clk = 1'b0, sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic rd_req = 1'b0, fail_req = 1'b0, array_rd, exec_fail, flash_irq, stop_ack;
  logic [23:0] rd_req_addr = 24'h00_0000, array_rd_addr;
  logic [31:0] exec_result, backdoor_key, s;
  logic [7:0] codes [10] = '{fcs_pkg::CMD_RD1SEC, fcs_pkg::CMD_PGMCHK, fcs_pkg::CMD_RDRSRC,
    fcs_pkg::CMD_PGM4, fcs_pkg::CMD_ERSSCR, fcs_pkg::CMD_RD1ALL, fcs_pkg::CMD_RDONCE,
    fcs_pkg::CMD_PGMONCE, fcs_pkg::CMD_ERSALL, fcs_pkg::CMD_VFYKEY};
  int n_errors = 0, check_count = 0;

  fcs_top DUT (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .array_rd, .array_rd_addr, .exec_fail,
    .exec_result, .backdoor_key, .flash_irq, .stop_ack);
  fcs_flash_model #(.KEY_WORD(KEY), .RESULT_WORD(RES)) MODEL (.sys_clk, .rd_req,
    .rd_req_addr, .fail_req, .array_rd, .array_rd_addr, .exec_fail, .exec_result,
    .backdoor_key);

  // ==========================================
  // clock and watchdog; whole run is far below this span
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  // ==========================================
  // tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit got = 0;
    bit [1:0] tk = 2'b00;
    rs = 2'b11;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (!got) begin
      @(posedge sys_clk);
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        got = 1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        tk[1] = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        tk[0] = 1'b1;
      end
    end
    chk("write answer", 32'(tk), 32'd3); // response only after both were taken
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit got = 0;
    bit tk = 1'b0;
    rs = 2'b11;
    d = 32'h0000_0000;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      if (s_axi_rvalid && s_axi_rready) begin
        rs = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        got = 1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        tk = 1'b1;
      end
    end
    chk("read answer", 32'(tk), 32'd1); // data only after the address was taken
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rs;
    wr(a, d, rs);
    chk("write resp", 32'(rs), 32'd0);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    logic [1:0] rs;
    rd(a, d, rs);
    chk(name, d, exp);
  endtask
  // parameters in the order data, count, address, then launch
  task automatic launch(input logic [7:0] code, input logic [23:0] a, input logic [31:0] d);
    w(fcs_pkg::OFS_PARAM2, d);
    w(fcs_pkg::OFS_PARAM1, 32'h0001_0000);
    w(fcs_pkg::OFS_PARAM0, {code, a});
    w(fcs_pkg::OFS_STATUS, CC);
  endtask
  task automatic done_st(output logic [31:0] st);
    logic [1:0] rs;
    st = 32'h0000_0000;
    for (int n = 0; n < 40 && st[fcs_pkg::ST_CC] !== 1'b1; n++) rd(fcs_pkg::OFS_STATUS, st, rs);
  endtask
  task automatic cmd(input logic [7:0] code, input logic [23:0] a, input logic [31:0] d,
    input logic [31:0] exp, input string name);
    logic [31:0] st;
    launch(code, a, d);
    done_st(st);
    chk(name, st, exp);
    w(fcs_pkg::OFS_STATUS, ACC | PV);
  endtask

  // ==========================================
  // test sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(fcs_pkg::OFS_STATUS, CC, "status at reset");
    rd(fcs_pkg::OFS_SYSCTL, s, r);
    chk("secure at reset", 32'(s[fcs_pkg::SC_SECURE]), 32'd1);
    // special mode while secured: mass field blocks all, else only verify/erase-all
    w(fcs_pkg::OFS_SYSCTL, 32'h0000_0021);
    cmd(fcs_pkg::CMD_RD1ALL, 24'h00_0000, 0, CC | ACC, "mass field");
    w(fcs_pkg::OFS_SYSCTL, 32'h0000_0001);
    cmd(fcs_pkg::CMD_PGM4, 24'h00_0000, 0, CC | ACC, "secured program");
    cmd(fcs_pkg::CMD_RD1ALL, 24'h00_0000, 0, CC, "secured verify");
    rd(fcs_pkg::OFS_SYSCTL, s, r);
    chk("released", 32'(s[fcs_pkg::SC_SECURE]), 32'd0);
    cmd(fcs_pkg::CMD_PGM4, 24'h00_0000, 0, CC, "unsecured program");
    w(fcs_pkg::OFS_SYSCTL, 32'h0000_0000);
    // every code accepted in normal mode; read codes return the array result
    foreach (codes[i]) begin
      cmd(codes[i], 24'h00_0000, KEY, CC, "code accepted");
      if (codes[i] == fcs_pkg::CMD_RDRSRC || codes[i] == fcs_pkg::CMD_RDONCE)
        rc(fcs_pkg::OFS_PARAM2, RES, "read result");
    end
    // refused commands, then a blocked launch
    cmd(8'h07, 24'h00_0000, 0, CC | ACC, "bad code");
    cmd(fcs_pkg::CMD_VFYKEY, 24'h00_0000, ~KEY, CC | ACC, "bad key");
    launch(fcs_pkg::CMD_PGM4, fcs_pkg::FLASH_TOP, 0);
    done_st(s);
    chk("out of range", s, CC | ACC);
    w(fcs_pkg::OFS_STATUS, CC);
    rc(fcs_pkg::OFS_STATUS, CC | ACC, "blocked launch");
    w(fcs_pkg::OFS_STATUS, ACC | PV);
    rc(fcs_pkg::OFS_STATUS, CC, "errors cleared");
    // region 0 protected
    w(fcs_pkg::OFS_PROT, 32'hFFFF_FFFE);
    cmd(fcs_pkg::CMD_ERSSCR, 24'h00_0000, 0, CC | PV, "protected erase");
    cmd(fcs_pkg::CMD_ERSALL, 24'h00_0000, 0, CC | PV, "protected full erase");
    cmd(fcs_pkg::CMD_PGM4, 24'h00_4000, 0, CC, "open region");
    // collision in the running block, ignored parameter write, interrupts
    w(fcs_pkg::OFS_CONFIG, 32'(1) << fcs_pkg::CF_RCIE);
    launch(fcs_pkg::CMD_PGM4, 24'h00_4100, 0);
    w(fcs_pkg::OFS_PARAM1, 32'h1234_0000);
    @(posedge sys_clk);
    rd_req <= 1'b1;
    rd_req_addr <= 24'h00_0010;
    @(posedge sys_clk);
    rd_req <= 1'b0;
    done_st(s);
    chk("collision", s, CC | RC);
    chk("collision irq", 32'(flash_irq), 32'd1);
    rc(fcs_pkg::OFS_PARAM1, 32'h0001_0000, "param held");
    w(fcs_pkg::OFS_STATUS, RC);
    rc(fcs_pkg::OFS_STATUS, CC, "collision cleared");
    chk("irq off", 32'(flash_irq), 32'd0);
    w(fcs_pkg::OFS_CONFIG, 32'(1) << fcs_pkg::CF_CMD_COMPLETE_IRQ_ENABLE);
    repeat (2) @(posedge sys_clk);
    chk("complete irq", 32'(flash_irq), 32'd1);
    w(fcs_pkg::OFS_CONFIG, 32'h0000_0000);
    // busy flag and a stop request during a command
    launch(fcs_pkg::CMD_PGM4, 24'h00_4000, 0);
    rc(fcs_pkg::OFS_STATUS, 32'h0000_0000, "busy");
    w(fcs_pkg::OFS_SYSCTL, 32'(1) << fcs_pkg::SC_STOPREQ);
    chk("stop held", 32'(stop_ack), 32'd0);
    done_st(s);
    @(posedge sys_clk);
    chk("stop granted", 32'(stop_ack), 32'd1);
    // launch ignored in very low power
    w(fcs_pkg::OFS_SYSCTL, 32'(1) << fcs_pkg::SC_VLP);
    w(fcs_pkg::OFS_STATUS, CC);
    rc(fcs_pkg::OFS_STATUS, CC, "low power launch");
    w(fcs_pkg::OFS_SYSCTL, 32'h0000_0000);
    // run-time failure hidden behind access error, then reported
    @(posedge sys_clk);
    fail_req <= 1'b1;
    cmd(fcs_pkg::CMD_RD1SEC, fcs_pkg::FLASH_TOP, 0, CC | ACC, "failure hidden");
    launch(fcs_pkg::CMD_RD1SEC, 24'h00_4000, 0);
    done_st(s);
    chk("run failure", s, CC | MG);
    fail_req <= 1'b0;
    // reset in mid-command brings back the idle flags and security
    launch(fcs_pkg::CMD_PGM4, 24'h00_4000, 0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(fcs_pkg::OFS_STATUS, CC, "status after reset");
    rc(fcs_pkg::OFS_SYSCTL, 32'h0000_0002, "secure after reset");
    // unmapped offset
    wr(8'h1C, 32'h0000_0000, r);
    chk("unmapped write", 32'(r), 32'd2);
    rd(8'h1C, s, r);
    chk("unmapped read", {s[29:0], r}, 32'd2);
    close_out();
  end
endmodule
